/* File: usb_otg_sie_map.svh */
// register offsets, field positions, reset values and counts of the sie control block
`ifndef USB_OTG_SIE_MAP_SVH
`define USB_OTG_SIE_MAP_SVH
// ==========================================================
// register offsets
`define SIE_REG_CON     8'h00
`define SIE_REG_PWR     8'h01
`define SIE_REG_OTG     8'h02
`define SIE_REG_IR      8'h03
`define SIE_REG_IE      8'h04
`define SIE_REG_EIR     8'h05
`define SIE_REG_EIE     8'h06
`define SIE_REG_EP0     8'h07
`define SIE_REG_ADDR    8'h08
`define SIE_REG_TOK     8'h09
`define SIE_REG_PWMRATE 8'h0A
`define SIE_REG_PWMCTL  8'h0B
`define SIE_REG_STALL   8'h0C
// ==========================================================
// field positions
`define SIE_CON_EN      0
`define SIE_CON_PPRST   1
`define SIE_CON_HOST    3
`define SIE_CON_BUSRST  4
`define SIE_CON_JST     7
`define SIE_PWR_UP      0
`define SIE_OTG_VDIS    0
`define SIE_OTG_VTGT    1
`define SIE_OTG_OTGON   2
`define SIE_OTG_VON     3
`define SIE_OTG_DMPD    4
`define SIE_OTG_DPPD    5
`define SIE_OTG_DMPU    6
`define SIE_OTG_DPPU    7
`define SIE_IR_ERR      1
`define SIE_IR_TRN      3
`define SIE_IR_STALL    5
`define SIE_IR_ATT      6
`define SIE_EP0_HSHK    0
`define SIE_EP0_RETRYOFF 6
`define SIE_EP0_LS      7
`define SIE_ADDR_LS     7
`define SIE_PWM_POL     9
`define SIE_PWM_CNT     8
`define SIE_PWM_ON      15
`define SIE_BD_OWN      15
`define SIE_BD_TGL      14
`define SIE_BD_TGLEN    11
`define SIE_BD_STALL    10
// ==========================================================
// values
`define SIE_RST8        8'h00
`define SIE_RST16       16'h0000
`define SIE_PID_IN      4'h9
`define SIE_PID_ERR     4'hF
`define SIE_FRAME_LOAD  14'h2EE0
`endif

/* File: usb_otg_sie_pkg.sv */
// types shared by the sie control block
package usb_otg_sie_pkg;
  // ==========================================================
  // descriptor engine states, gray along the usual path from ST_IDLE up to ST_FLAG
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_FETCH  = 3'h1,
    ST_DECIDE = 3'h3,
    ST_LAUNCH = 3'h2,
    ST_MOVE   = 3'h6,
    ST_STORE  = 3'h7,
    ST_FLAG   = 3'h5
  } sie_state_t;
endpackage : usb_otg_sie_pkg

/* File: boost_pwm.sv */
// pwm generator driving the vbus boost switch
`timescale 1ns/10ps
`default_nettype none
module boost_pwm (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] period,
  input  wire logic [7:0] duty,
  input  wire logic       countOn,
  input  wire logic       pwmOn,
  input  wire logic       invert,
  output logic            pwmOut
);
  // ==========================================================
  // counter and output stage
  logic [7:0] cnt_ff;
  logic       out_ff;
  wire        wrap  = (cnt_ff >= period);
  wire        hiPh  = pwmOn && countOn && (cnt_ff < duty);

  // counter holds at zero while stopped so restart is glitch free
  always_ff @(posedge clk_sys) begin
    if (rst || !countOn || wrap) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // registered output avoids comparator glitches on the switch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= hiPh ^ invert;
    end
  end

  assign pwmOut = out_ff;
endmodule : boost_pwm
`default_nettype wire

/* File: frame_timer.sv */
// start-of-frame interval counter for host mode
`timescale 1ns/10ps
`default_nettype none
`include "usb_otg_sie_map.svh"
module frame_timer #(
  parameter logic [13:0] LOAD = `SIE_FRAME_LOAD
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic        run,
  output logic             sofPulse,
  output logic      [13:0] frameCnt
);
  // ==========================================================
  // down counter, reloads in the same cycle as each frame mark
  logic [13:0] cnt_ff;
  logic        sof_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_ff <= 14'h0000;
      sof_ff <= 1'b0;
    end else if (load) begin
      cnt_ff <= LOAD;
      sof_ff <= 1'b0;
    end else if (run && cnt_ff <= 14'h0001) begin
      cnt_ff <= LOAD;
      sof_ff <= 1'b1;
    end else if (run) begin
      cnt_ff <= cnt_ff - 14'h0001;
      sof_ff <= 1'b0;
    end else begin
      sof_ff <= 1'b0;
    end
  end

  assign sofPulse = sof_ff;
  assign frameCnt = cnt_ff;
endmodule : frame_timer
`default_nettype wire

/* File: usb_otg_sie_control.sv */
// control side of the usb otg serial interface engine
//
// What this block does
// - owner bit clear means descriptor is software's; ignore every other field.
// - toggle bit picks DATA1/DATA0, used only when toggle sync enable set.
// - with toggle sync on, drop received packets with wrong toggle.
// - stall bit gives STALL, keeps descriptor untouched, sets endpoint stall status.
// - byte count is limit; overwritten with bytes actually moved.
// - boost pwm period/duty in rate register; polarity, counter, enable in control.
// - every interrupt source leaves on one shared interrupt line.
// - top flags plus enabled error flags; any enabled error sets summary flag.
// - flags set by hardware only; writing one clears, zero keeps.
// - device mode works per transfer and handshakes status phase itself.
// - IN token on owned descriptor sends buffer, updates status, sets done flag.
// - OUT token on owned descriptor stores data, updates status, sets done flag.
// - host mode transfers start by software and use endpoint zero only.
// - host enable makes host-only controls take effect.
// - entering host starts frame marks from 12000; clearing enable stops them.
// - SE0 to J on the lines sets the attach flag.
// - J-state bit zero means low speed device attached.
// - bus reset bit held set drives reset signalling.
// - owner bit set gives module the descriptor; module may rewrite it.
// - host mode writes peer handshake or error code into pid field.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "usb_otg_sie_map.svh"
module usb_otg_sie_control #(
  parameter logic [13:0] FRAME_LOAD = `SIE_FRAME_LOAD
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  input  wire logic        dpLine,
  input  wire logic        dmLine,
  input  wire logic [7:0]  errEvent,
  input  wire logic        tokValid,
  input  wire logic [3:0]  tokPid,
  input  wire logic [3:0]  tokEp,
  output logic      [4:0]  bdIndex,
  output logic             bdRdEn,
  input  wire logic [15:0] bdRdData,
  output logic             bdWrEn,
  output logic      [15:0] bdWrData,
  output logic             pktTxReq,
  output logic      [9:0]  pktTxCount,
  output logic             pktTxToggle,
  input  wire logic        pktTxDone,
  output logic             pktRxArm,
  input  wire logic        pktRxDone,
  input  wire logic [9:0]  pktRxCount,
  input  wire logic        pktRxToggle,
  input  wire logic [3:0]  pktHsPid,
  input  wire logic        pktErr,
  output logic             hsAck,
  output logic             hsNak,
  output logic             hsStall,
  output logic             hostTokReq,
  output logic      [7:0]  hostTok,
  output logic             sofPulse,
  output logic             busResetDrive,
  output logic             lowSpeedMode,
  output logic             dpPullUp,
  output logic             dmPullUp,
  output logic             dpPullDown,
  output logic             dmPullDown,
  output logic             vbusGenEnable,
  output logic             vbusDischarge,
  output logic             vbusTarget,
  output logic             boostPwmOut,
  output logic             modulePowered,
  output logic             moduleEnabled,
  output logic             otgEnabled,
  output logic             pingPongReset,
  output logic             usbIrq
);
  // ==========================================================
  // storage
  logic [7:0]  con_ff, pwr_ff, otg_ff, ir_ff, ie_ff, eir_ff, eie_ff;
  logic [7:0]  ep0_ff, addr_ff, tok_ff;
  logic [15:0] pwmRate_ff, pwmCtl_ff, stall_ff, rdData_ff, bd_ff, wrWord_ff;
  logic [1:0]  lineS1_ff, lineS2_ff;
  logic        se0Prev_ff, tokReq_ff, isTx_ff, isHost_ff;
  logic [3:0]  pid_ff, ep_ff;
  usb_otg_sie_pkg::sie_state_t st_ff, nxt_st;

  // sticky flag update: a set in the same cycle as a clear wins
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] set,
                                     input logic [7:0] clr);
    w1c = set | (cur & ~clr);
  endfunction : w1c

  // ==========================================================
  // register decode
  wire wrCon   = regWr && (regAddr == `SIE_REG_CON);
  wire wrIr    = regWr && (regAddr == `SIE_REG_IR);
  wire wrEir   = regWr && (regAddr == `SIE_REG_EIR);
  wire wrStall = regWr && (regAddr == `SIE_REG_STALL);
  wire wrTok   = regWr && (regAddr == `SIE_REG_TOK);
  wire host_mode_enable  = con_ff[`SIE_CON_HOST];
  wire [7:0] wd8 = regWrData[7:0];
  // host bit rising forces frame generation on
  wire hostRise = wrCon && wd8[`SIE_CON_HOST] && !host_mode_enable;

  // ==========================================================
  // line synchronisers and attach detect
  wire [1:0] lineNow = lineS2_ff;
  wire line_j_state_status  = lineNow[0] && !lineNow[1];
  wire attachEvt = host_mode_enable && se0Prev_ff && (|lineNow);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lineS1_ff  <= 2'h0;
      lineS2_ff  <= 2'h0;
      se0Prev_ff <= 1'b0;
    end else begin
      lineS1_ff  <= {dmLine, dpLine};
      lineS2_ff  <= lineS1_ff;
      se0Prev_ff <= (lineS2_ff == 2'h0);
    end
  end

  // ==========================================================
  // descriptor engine decode
  wire devStart  = tokValid && con_ff[`SIE_CON_EN] && !host_mode_enable;
  wire hostStart = tokReq_ff;
  wire idle      = (st_ff == usb_otg_sie_pkg::ST_IDLE);
  wire start     = idle && (devStart || hostStart);
  wire [3:0] sPid = hostStart ? tok_ff[7:4] : tokPid;
  // host side sends unless the token is IN; device side sends on IN
  wire sTx       = hostStart ? (sPid != `SIE_PID_IN) : (sPid == `SIE_PID_IN);
  wire owned     = bdRdData[`SIE_BD_OWN];
  wire stallBd   = owned && bdRdData[`SIE_BD_STALL];
  wire decide    = (st_ff == usb_otg_sie_pkg::ST_DECIDE);
  wire move      = (st_ff == usb_otg_sie_pkg::ST_MOVE);
  wire stallHit  = decide && stallBd;
  wire tglMiss   = bd_ff[`SIE_BD_TGLEN] && (pktRxToggle != bd_ff[`SIE_BD_TGL]);
  wire rxDrop    = move && !isTx_ff && pktRxDone && (tglMiss || (pktErr && !isHost_ff));
  wire rxKeep    = move && !isTx_ff && pktRxDone && !rxDrop;
  wire txFin     = move && isTx_ff && pktTxDone;
  wire [9:0] bdCnt = bd_ff[9:0];
  // a packet longer than the limit is cut to the limit
  wire [9:0] rxCnt = (pktRxCount > bdCnt) ? bdCnt : pktRxCount;
  wire [3:0] hsRes = pktErr ? `SIE_PID_ERR : pktHsPid;
  wire [3:0] resPid = isHost_ff ? hsRes : pid_ff;
  wire [9:0] resCnt = isTx_ff ? bdCnt : rxCnt;
  wire trnSet    = (st_ff == usb_otg_sie_pkg::ST_FLAG);

  // next state of the descriptor engine
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      usb_otg_sie_pkg::ST_IDLE:   if (start) nxt_st = usb_otg_sie_pkg::ST_FETCH;
      usb_otg_sie_pkg::ST_FETCH:  nxt_st = usb_otg_sie_pkg::ST_DECIDE;
      usb_otg_sie_pkg::ST_DECIDE: begin
        if (!owned || stallBd) begin
          nxt_st = usb_otg_sie_pkg::ST_IDLE;
        end else begin
          nxt_st = usb_otg_sie_pkg::ST_LAUNCH;
        end
      end
      usb_otg_sie_pkg::ST_LAUNCH: nxt_st = usb_otg_sie_pkg::ST_MOVE;
      usb_otg_sie_pkg::ST_MOVE: begin
        if (rxDrop) begin
          nxt_st = usb_otg_sie_pkg::ST_IDLE;
        end else if (rxKeep || txFin) begin
          nxt_st = usb_otg_sie_pkg::ST_STORE;
        end
      end
      usb_otg_sie_pkg::ST_STORE:  nxt_st = usb_otg_sie_pkg::ST_FLAG;
      usb_otg_sie_pkg::ST_FLAG:   nxt_st = usb_otg_sie_pkg::ST_IDLE;
      default:                    nxt_st = usb_otg_sie_pkg::ST_IDLE;
    endcase
  end

  // engine state and token capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff     <= usb_otg_sie_pkg::ST_IDLE;
      isTx_ff   <= 1'b0;
      isHost_ff <= 1'b0;
      pid_ff    <= 4'h0;
      ep_ff     <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      if (start) begin
        isTx_ff   <= sTx;
        isHost_ff <= hostStart;
        pid_ff    <= sPid;
        ep_ff     <= hostStart ? 4'h0 : tokEp;
      end
    end
  end

  // descriptor latch and writeback word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bd_ff     <= `SIE_RST16;
      wrWord_ff <= `SIE_RST16;
    end else begin
      if (decide) begin
        bd_ff <= bdRdData;
      end
      if (rxKeep || txFin) begin
        wrWord_ff <= {1'b0, bd_ff[`SIE_BD_TGL], resPid, resCnt};
      end
    end
  end

  // ==========================================================
  // software registers
  wire [7:0] irSet = {1'b0, attachEvt, stallHit, 1'b0, trnSet, 3'h0};
  wire [15:0] stallSet = stallHit ? (16'h0001 << ep_ff) : 16'h0000;
  wire [7:0] irClr = wrIr ? wd8 : 8'h00;
  wire [7:0] eirClr = wrEir ? wd8 : 8'h00;
  wire [15:0] stClr = wrStall ? regWrData : 16'h0000;
  wire errSum = |(eir_ff & eie_ff);
  wire [7:0] irView = ir_ff | {6'h00, errSum, 1'b0};

  // control registers; plain stores except con, which clears bit 7 and sets the enable bit on host entry
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      con_ff     <= `SIE_RST8;
      pwr_ff     <= `SIE_RST8;
      otg_ff     <= `SIE_RST8;
      ie_ff      <= `SIE_RST8;
      eie_ff     <= `SIE_RST8;
      ep0_ff     <= `SIE_RST8;
      addr_ff    <= `SIE_RST8;
      pwmRate_ff <= `SIE_RST16;
      pwmCtl_ff  <= `SIE_RST16;
    end else if (regWr) begin
      unique case (regAddr)
        `SIE_REG_CON:     con_ff <= {1'b0, wd8[6:1], wd8[0] | hostRise};
        `SIE_REG_PWR:     pwr_ff <= wd8;
        `SIE_REG_OTG:     otg_ff <= wd8;
        `SIE_REG_IE:      ie_ff <= wd8;
        `SIE_REG_EIE:     eie_ff <= wd8;
        `SIE_REG_EP0:     ep0_ff <= wd8;
        `SIE_REG_ADDR:    addr_ff <= wd8;
        `SIE_REG_PWMRATE: pwmRate_ff <= regWrData;
        `SIE_REG_PWMCTL:  pwmCtl_ff <= regWrData;
        default:          ;
      endcase
    end
  end

  // sticky flags and host token launch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ir_ff     <= `SIE_RST8;
      eir_ff    <= `SIE_RST8;
      stall_ff  <= `SIE_RST16;
      tok_ff    <= `SIE_RST8;
      tokReq_ff <= 1'b0;
    end else begin
      ir_ff           <= w1c(ir_ff, irSet, irClr);
      eir_ff          <= w1c(eir_ff, errEvent, eirClr);
      stall_ff[15:8]  <= w1c(stall_ff[15:8], stallSet[15:8], stClr[15:8]);
      stall_ff[7:0]   <= w1c(stall_ff[7:0], stallSet[7:0], stClr[7:0]);
      // a token written while the engine is busy is dropped
      tokReq_ff <= wrTok && host_mode_enable && idle && !tokReq_ff;
      if (wrTok) begin
        tok_ff <= wd8;
      end
    end
  end

  // read mux; j-state is live from the synchronised lines
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    unique case (regAddr)
      `SIE_REG_CON:     rdMux = {8'h00, line_j_state_status, con_ff[6:0]};
      `SIE_REG_PWR:     rdMux = {8'h00, pwr_ff};
      `SIE_REG_OTG:     rdMux = {8'h00, otg_ff};
      `SIE_REG_IR:      rdMux = {8'h00, irView};
      `SIE_REG_IE:      rdMux = {8'h00, ie_ff};
      `SIE_REG_EIR:     rdMux = {8'h00, eir_ff};
      `SIE_REG_EIE:     rdMux = {8'h00, eie_ff};
      `SIE_REG_EP0:     rdMux = {8'h00, ep0_ff};
      `SIE_REG_ADDR:    rdMux = {8'h00, addr_ff};
      `SIE_REG_TOK:     rdMux = {8'h00, tok_ff};
      `SIE_REG_PWMRATE: rdMux = pwmRate_ff;
      `SIE_REG_PWMCTL:  rdMux = pwmCtl_ff;
      `SIE_REG_STALL:   rdMux = stall_ff;
      default:          rdMux = 16'h0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_ff <= `SIE_RST16;
    end else begin
      rdData_ff <= regRd ? rdMux : 16'h0000;
    end
  end

  // ==========================================================
  // vbus boost and frame timing
  boost_pwm u_pwm (
    .clk_sys (clk_sys),
    .rst     (rst),
    .period  (pwmRate_ff[7:0]),
    .duty    (pwmRate_ff[15:8]),
    .countOn (pwmCtl_ff[`SIE_PWM_CNT]),
    .pwmOn   (pwmCtl_ff[`SIE_PWM_ON]),
    .invert  (pwmCtl_ff[`SIE_PWM_POL]),
    .pwmOut  (boostPwmOut)
  );

  logic [13:0] frameCnt;
  frame_timer #(.LOAD(FRAME_LOAD)) u_frame (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .load     (hostRise),
    .run      (host_mode_enable && con_ff[`SIE_CON_EN]),
    .sofPulse (sofPulse),
    .frameCnt (frameCnt)
  );

  // ==========================================================
  // outputs
  assign regRdData     = rdData_ff;
  assign bdIndex       = {ep_ff, isTx_ff};
  assign bdRdEn        = (st_ff == usb_otg_sie_pkg::ST_FETCH);
  assign bdWrEn        = (st_ff == usb_otg_sie_pkg::ST_STORE);
  assign bdWrData      = wrWord_ff;
  assign pktTxReq      = (st_ff == usb_otg_sie_pkg::ST_LAUNCH) && isTx_ff;
  assign pktTxCount    = bd_ff[9:0];
  assign pktTxToggle   = bd_ff[`SIE_BD_TGLEN] && bd_ff[`SIE_BD_TGL];
  assign pktRxArm      = (move || st_ff == usb_otg_sie_pkg::ST_LAUNCH) && !isTx_ff;
  // device answers the status phase and data stages on its own
  assign hsAck         = bdWrEn && !isHost_ff && !isTx_ff && ep0_ff[`SIE_EP0_HSHK];
  assign hsNak         = decide && !owned && !isHost_ff;
  assign hsStall       = stallHit && !isHost_ff;
  assign hostTokReq    = tokReq_ff;
  assign hostTok       = tok_ff;
  assign busResetDrive = host_mode_enable && con_ff[`SIE_CON_BUSRST];
  assign lowSpeedMode  = host_mode_enable && addr_ff[`SIE_ADDR_LS] && ep0_ff[`SIE_EP0_LS];
  assign dpPullUp      = otg_ff[`SIE_OTG_DPPU];
  assign dmPullUp      = otg_ff[`SIE_OTG_DMPU];
  assign dpPullDown    = otg_ff[`SIE_OTG_DPPD];
  assign dmPullDown    = otg_ff[`SIE_OTG_DMPD];
  assign vbusGenEnable = otg_ff[`SIE_OTG_VON];
  assign vbusDischarge = otg_ff[`SIE_OTG_VDIS];
  assign vbusTarget    = otg_ff[`SIE_OTG_VTGT];
  assign modulePowered = pwr_ff[`SIE_PWR_UP];
  assign moduleEnabled = con_ff[`SIE_CON_EN] && !host_mode_enable;
  assign otgEnabled    = otg_ff[`SIE_OTG_OTGON];
  assign pingPongReset = con_ff[`SIE_CON_PPRST];
  assign usbIrq        = |(irView & ie_ff);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_wb;
    bdWrEn && !bdWrData[`SIE_BD_OWN];
  endsequence
  sequence s_flag;
    ##2 ir_ff[`SIE_IR_TRN];
  endsequence

  property p_own_ignore;
    decide && !owned |-> !pktTxReq && !bdWrEn ##1 idle;
  endproperty
  a_own_ignore: assert property (p_own_ignore) else $error("unowned bd not ignored");

  property p_stall;
    decide && stallBd |=> idle && stall_ff[ep_ff] && !bdWrEn;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not handled");

  property p_release;
    bdWrEn |-> s_wb ##0 s_flag;
  endproperty
  a_release: assert property (p_release) else $error("bd not released before flag");

  property p_toggle_drop;
    rxDrop |=> idle ##1 !bdWrEn;
  endproperty
  a_toggle_drop: assert property (p_toggle_drop) else $error("bad toggle kept");

  property p_w1c_zero;
    wrIr && !wd8[`SIE_IR_TRN] && !trnSet |=> ir_ff[`SIE_IR_TRN] == $past(ir_ff[`SIE_IR_TRN]);
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) else $error("zero write changed flag");

  property p_host_frames;
    hostRise |=> con_ff[`SIE_CON_EN] && frameCnt == FRAME_LOAD;
  endproperty
  a_host_frames: assert property (p_host_frames) else $error("frames not started");

  property p_attach;
    attachEvt |=> ir_ff[`SIE_IR_ATT];
  endproperty
  a_attach: assert property (p_attach) else $error("attach flag missing");

  property p_err_funnel;
    |(errEvent & eie_ff) && ie_ff[`SIE_IR_ERR] && !regWr |=> usbIrq;
  endproperty
  a_err_funnel: assert property (p_err_funnel) else $error("error not funnelled");

  property p_count;
    rxKeep |=> bdWrEn && bdWrData[9:0] == $past(rxCnt);
  endproperty
  a_count: assert property (p_count) else $error("byte count not written");
endmodule : usb_otg_sie_control
`default_nettype wire

/* File: usb_peer_model.sv */
// far side model: descriptor memory read port and packet engine
`timescale 1ns/10ps
`default_nettype none
module usb_peer_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [15:0] bdWord,
  input  wire logic [3:0]  lat,
  input  wire logic [9:0]  rxCnt,
  input  wire logic        rxTgl,
  input  wire logic        bdRdEn,
  output logic      [15:0] bdRdData,
  input  wire logic        pktTxReq,
  input  wire logic        pktRxArm,
  output logic             pktTxDone,
  output logic             pktRxDone,
  output logic      [9:0]  pktRxCount,
  output logic             pktRxToggle
);
  logic [3:0] wait_ff;
  logic       busy_ff;
  logic       isRx_ff;
  // outside the done cycle the fields show inverted values
  assign pktRxCount  = pktRxDone ? rxCnt : ~rxCnt;
  assign pktRxToggle = pktRxDone ? rxTgl : ~rxTgl;
  // word one cycle after fetch; done lat+2 cycles after the request
  always_ff @(posedge clk_sys) begin
    bdRdData  <= bdRdEn ? bdWord : ~bdRdData;
    pktTxDone <= 1'b0;
    pktRxDone <= 1'b0;
    wait_ff   <= wait_ff - 4'h1;
    if (rst) begin
      busy_ff <= 1'b0;
    end else if (!busy_ff && (pktTxReq || (pktRxArm && !pktRxDone))) begin
      busy_ff <= 1'b1;
      isRx_ff <= pktRxArm;
      wait_ff <= lat;
    end else if (busy_ff && wait_ff == 4'h0) begin
      busy_ff   <= 1'b0;
      pktTxDone <= !isRx_ff;
      pktRxDone <= isRx_ff;
    end
  end
endmodule : usb_peer_model
`default_nettype wire

/* File: usb_otg_sie_control_tb.sv */
// self-checking bench of the sie control block
`timescale 1ns/10ps
`default_nettype none
`include "usb_otg_sie_map.svh"
module usb_otg_sie_control_tb;
  logic        clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, dpLine = 1'b0;
  logic        dmLine = 1'b0, tokValid = 1'b0, rxTgl = 1'b0, seenWb, seenSt, seenSof;
  logic        bdRdEn, bdWrEn, pktTxReq, pktTxDone, pktRxArm, pktRxDone, pktRxToggle;
  logic        hsStall, sofPulse, busResetDrive, usbIrq, boostPwmOut;
  logic [3:0]  tokPid = 4'h0, tokEp = 4'h0, lat = 4'h0;
  logic [7:0]  regAddr = 8'h00, errEvent = 8'h00;
  logic [9:0]  rxCnt = 10'h000, pktRxCount;
  logic [15:0] regWrData = 16'h0000, bdWord = 16'h0000, regRdData, bdRdData, bdWrData, wb;
  int          miscompares = 0, comparisons = 0;
  // bring-up writes {offset, data}
  localparam logic [23:0] BOOT [12] = '{24'h000002, 24'h000000, 24'h040000, 24'h060000,
    24'h0300FF, 24'h0500FF, 24'h000001, 24'h020004, 24'h070009, 24'h010001, 24'h020084,
    24'h04004A};
  always #50 clk_sys = ~clk_sys;
  usb_otg_sie_control #(.FRAME_LOAD(14'h0010)) u_dut (.clk_sys, .rst, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .dpLine, .dmLine, .errEvent, .tokValid, .tokPid, .tokEp,
    .bdIndex(), .bdRdEn, .bdRdData, .bdWrEn, .bdWrData, .pktTxReq, .pktTxCount(),
    .pktTxToggle(), .pktTxDone, .pktRxArm, .pktRxDone, .pktRxCount, .pktRxToggle,
    .pktHsPid(4'h2), .pktErr(1'b0), .hsAck(), .hsNak(), .hsStall, .hostTokReq(), .hostTok(),
    .sofPulse, .busResetDrive, .lowSpeedMode(), .dpPullUp(), .dmPullUp(), .dpPullDown(),
    .dmPullDown(), .vbusGenEnable(), .vbusDischarge(), .vbusTarget(), .boostPwmOut,
    .modulePowered(), .moduleEnabled(), .otgEnabled(), .pingPongReset(), .usbIrq);
  usb_peer_model u_peer (.clk_sys, .rst, .bdWord, .lat, .rxCnt, .rxTgl, .bdRdEn, .bdRdData,
    .pktTxReq, .pktRxArm, .pktTxDone, .pktRxDone, .pktRxCount, .pktRxToggle);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(regRdData & m, e);
  endtask : rdc
  // one token, then watch the engine for a fixed window
  task automatic xfer(input logic [3:0] p, input logic [3:0] e, input logic [15:0] bd);
    @(posedge clk_sys);
    bdWord   <= bd;
    tokValid <= 1'b1;
    tokPid   <= p;
    tokEp    <= e;
    @(posedge clk_sys);
    tokValid <= 1'b0;
    seenWb = 1'b0;
    seenSt = 1'b0;
    repeat (30) begin
      @(posedge clk_sys);
      #1;
      if (bdWrEn === 1'b1) begin
        seenWb = 1'b1;
        wb     = bdWrData;
      end
      if (hsStall === 1'b1) seenSt = 1'b1;
    end
  endtask : xfer
  task automatic wfs(input int n);
    seenSof = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 if (sofPulse === 1'b1) seenSof = 1'b1;
    end
  endtask : wfs
  // writeback word with the toggle bit masked off
  function automatic logic [15:0] expWb(input logic [3:0] p, input logic [15:0] bd, input logic rx);
    logic [9:0] c;
    c = (rx && rxCnt < bd[9:0]) ? rxCnt : bd[9:0];
    return {2'b00, p, c};
  endfunction : expWb
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // watchdog well beyond the expected several hundred cycles
  initial begin
    #2000000;
    miscompares++;
    end_of_test();
  end
  // main sequence
  initial begin
    logic [15:0] bd;
    logic        rx;
    void'($urandom(32'h40d1));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(`SIE_REG_IR, 16'hFFFF, 16'h0000);
    rdc(8'h3F, 16'hFFFF, 16'h0000);
    foreach (BOOT[i]) wr(BOOT[i][23:16], BOOT[i][15:0]);
    for (int i = 0; i < 12; i++) begin
      rx = i[0];
      bd = {1'b1, 1'($urandom), 3'b001, 1'b0, 10'($urandom)};
      rxCnt <= 10'($urandom);
      rxTgl <= 1'($urandom);
      lat   <= 4'($urandom_range(7));
      xfer(rx ? 4'h1 : `SIE_PID_IN, 4'($urandom), bd);
      if (rx && rxTgl != bd[14]) begin
        chk(seenWb, 1'b0);
      end else begin
        chk(wb & 16'hBFFF, expWb(rx ? 4'h1 : 4'h9, bd, rx));
        rdc(`SIE_REG_IR, 16'h0008, 16'h0008);
        chk(usbIrq, 1'b1);
        wr(`SIE_REG_IR, 16'h0000);
        rdc(`SIE_REG_IR, 16'h0008, 16'h0008);
        wr(`SIE_REG_IR, 16'h0008);
        rdc(`SIE_REG_IR, 16'h0008, 16'h0000);
        chk(usbIrq, 1'b0);
      end
    end
    xfer(`SIE_PID_IN, 4'h3, 16'h0005);
    chk(seenWb, 1'b0);
    xfer(4'h1, 4'h5, 16'h8405);
    chk({seenWb, seenSt}, 2'b01);
    rdc(`SIE_REG_STALL, 16'hFFFF, 16'h0020);
    rdc(`SIE_REG_IR, 16'h0028, 16'h0020);
    // error enables must be open or the summary flag never rises
    wr(`SIE_REG_EIE, 16'h0005);
    errEvent <= 8'h05;
    @(posedge clk_sys);
    errEvent <= 8'h00;
    rdc(`SIE_REG_IR, 16'h0002, 16'h0002);
    chk(usbIrq, 1'b1);
    wr(`SIE_REG_EIR, 16'h00FF);
    rdc(`SIE_REG_IR, 16'h0002, 16'h0000);
    wr(`SIE_REG_CON, 16'h0008);
    wfs(40);
    chk(seenSof, 1'b1);
    // host OUT on ep0: the engine fetches two edges after the token write
    wr(`SIE_REG_TOK, 16'h0010);
    xfer(4'h1, 4'h0, 16'h8003);
    chk(wb & 16'hBFFF, expWb(4'h2, 16'h8003, 1'b0));
    dpLine <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(`SIE_REG_IR, 16'h0040, 16'h0040);
    rdc(`SIE_REG_CON, 16'h0080, 16'h0080);
    wr(`SIE_REG_CON, 16'h0018);
    #1 chk(busResetDrive, 1'b1);
    wfs(40);
    chk(seenSof, 1'b0);
    rdc(`SIE_REG_PWR, 16'h0001, 16'h0001);
    rdc(`SIE_REG_OTG, 16'h0001, 16'h0000);
    // zero duty: the switch output then shows the polarity alone
    bd = {8'h00, 8'($urandom)};
    wr(`SIE_REG_PWMRATE, bd);
    rdc(`SIE_REG_PWMRATE, 16'hFFFF, bd);
    chk(boostPwmOut, 1'b0);
    wr(`SIE_REG_OTG, 16'h0086);
    wr(`SIE_REG_PWMCTL, 16'h8300);
    rdc(`SIE_REG_PWMCTL, 16'h8300, 16'h8300);
    chk(boostPwmOut, 1'b1);
    wr(`SIE_REG_OTG, 16'h008E);
    end_of_test();
  end
endmodule : usb_otg_sie_control_tb
`default_nettype wire
